// ### core/dsv_pkg.sv
// constants, register map and source vectors of the trigger-vector block
//
// Overview of operation
// (R01) four channel registers route sources to transfer
// (R02) trigger is source whose vector equals register
// (R03) count zero: end interrupt, register cleared
// (R04) software rewrites register in end handler
// (R05) shared vector goes to lowest channel first
// (R06) cleared lower channel passes source upward
// (R07) vector field bits 7..2, write-only, reset zero
// (R08) codes 28H..3CH for inputs, FCH software
// (R09) software loads transfer parameters beforehand
// (R10) only nmi, input 0, input 5 selectable
// (R11) nmi falling edge, or both when set
// (R12) inputs 0, 5 rising edge or level
// (R13) level mode bypasses latch, follows pin
// (R14) edge to level clears pending flag
// (R15) level to edge keeps pending flag
// (R16) software clears flag after level-to-edge switch
// (R17) source holds level until response completes
// (R18) pin falling in level mode clears request
// (R19) clearing writes only with interrupts disabled
// (R20) disable interrupts before status restore
// (R21) latch cleared on accept, reset, vector read
// (R22) vector bits 1..0 ignored on write

package dsv_pkg;

    localparam int NUM_CHAN = 4;
    localparam int NUM_EXT  = 6;
    localparam int NUM_SRC  = 7;
    localparam int NUM_PIN  = 7;
    localparam int ADDR_W   = 12;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHAN0_VEC = 8'h26;
    localparam logic [7:0] IDX_CHAN1_VEC = 8'h27;
    localparam logic [7:0] IDX_CHAN2_VEC = 8'h28;
    localparam logic [7:0] IDX_CHAN3_VEC = 8'h29;
    localparam logic [7:0] IDX_MODE      = 8'h2A;
    localparam logic [7:0] IDX_REQ       = 8'h2B;
    localparam logic [7:0] IDX_START     = 8'h2C;
    localparam logic [7:0] IDX_STATUS    = 8'h2D;

    localparam int         VEC_LSB   = 2;
    localparam int         VEC_MSB   = 7;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;

    localparam logic [7:0] VEC_EXT0 = 8'h28;
    localparam logic [7:0] VEC_EXT1 = 8'h2C;
    localparam logic [7:0] VEC_EXT2 = 8'h30;
    localparam logic [7:0] VEC_EXT3 = 8'h34;
    localparam logic [7:0] VEC_EXT4 = 8'h38;
    localparam logic [7:0] VEC_EXT5 = 8'h3C;
    localparam logic [7:0] VEC_SW   = 8'hFC;

    localparam int MODE_NMI_BOTH = 0;
    localparam int MODE_EXT0_LVL = 1;
    localparam int MODE_EXT5_LVL = 2;
    localparam int START_BIT     = 0;

    localparam logic [2:0] SRC_EXT0 = 3'h0;
    localparam logic [2:0] SRC_EXT5 = 3'h5;
    localparam logic [2:0] SRC_SW   = 3'h6;
    localparam logic [2:0] SRC_NMI  = 3'h7;
    localparam int         PIN_NMI  = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // vector code of a routable source
    function automatic logic [7:0] vec_of(input int s);
        case (s)
            0: vec_of = VEC_EXT0;
            1: vec_of = VEC_EXT1;
            2: vec_of = VEC_EXT2;
            3: vec_of = VEC_EXT3;
            4: vec_of = VEC_EXT4;
            5: vec_of = VEC_EXT5;
            6: vec_of = VEC_SW;
            default: vec_of = VEC_RESET;
        endcase
    endfunction : vec_of

    // word-aligned address decode against a register index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        reg_hit = (a[ADDR_W-1:2] == {2'h0, idx});
    endfunction : reg_hit

endpackage : dsv_pkg

// ### core/dsv_core_if.sv
// signals between the top module, the pin detector and the router
`timescale 1ns/1ps
`default_nettype none

interface dsv_core_if;
    logic [dsv_pkg::NUM_PIN-1:0]       rise;
    logic [dsv_pkg::NUM_PIN-1:0]       fall;
    logic [dsv_pkg::NUM_PIN-1:0]       level;
    logic [dsv_pkg::NUM_CHAN-1:0][7:0] vec;
    logic [dsv_pkg::NUM_CHAN-1:0][2:0] ch_src;
    logic [dsv_pkg::NUM_CHAN-1:0]      ch_hit;

    modport det   (output rise, output fall, output level);
    modport route (input vec, output ch_src, output ch_hit);
    modport top   (input rise, input fall, input level,
                   output vec, input ch_src, input ch_hit);
endinterface : dsv_core_if

`default_nettype wire

// ### core/dsv_pin_detect.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module dsv_pin_detect #(
    parameter int N = dsv_pkg::NUM_PIN
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [N-1:0] pins,
    dsv_core_if.det           det
);
    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] last_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign det.level = sync_reg;
    assign det.rise  = sync_reg & ~last_reg;
    assign det.fall  = ~sync_reg & last_reg;
endmodule : dsv_pin_detect

`default_nettype wire

// ### core/dsv_chan_route.sv
// maps each channel vector to its source, lowest channel first
`timescale 1ns/1ps
`default_nettype none

module dsv_chan_route (
    dsv_core_if.route rt
);
    always_comb begin
        for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
            rt.ch_hit[c] = 1'b0;
            rt.ch_src[c] = 3'h0;
            for (int s = 0; s < dsv_pkg::NUM_SRC; s++) begin
                if (rt.vec[c] != dsv_pkg::VEC_RESET &&
                    rt.vec[c] == dsv_pkg::vec_of(s)) begin // R02
                    rt.ch_hit[c] = 1'b1;
                    rt.ch_src[c] = 3'(s);
                end
            end
            // a lower channel with the same vector owns the source
            for (int l = 0; l < c; l++) begin
                if (rt.vec[l] == rt.vec[c]) begin // R05
                    rt.ch_hit[c] = 1'b0;
                end
            end
        end
    end
endmodule : dsv_chan_route

`default_nettype wire

// ### core/dsv_irq_ctrl.sv
// trigger-vector routing and external input mode control
`timescale 1ns/1ps
`default_nettype none

module dsv_irq_ctrl (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite slave
    input  wire logic [dsv_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [dsv_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // external pins, asynchronous
    input  wire logic                          nmi_n,
    input  wire logic                          ext_irq_zero,
    input  wire logic [4:0]                    ext_irq_one_to_five,
    // cpu and transfer engine, same clock
    input  wire logic                          dma_accept,
    input  wire logic [1:0]                    dma_accept_chan,
    input  wire logic [dsv_pkg::NUM_CHAN-1:0]  transfer_count_zero,
    input  wire logic                          vec_read,
    input  wire logic [2:0]                    vec_read_src,
    output logic [dsv_pkg::NUM_CHAN-1:0]       dma_req,
    output logic [dsv_pkg::NUM_CHAN-1:0]       transfer_end_irq,
    output logic [dsv_pkg::NUM_EXT-1:0]        irq_req,
    output logic                               nmi_req
);

    ////////////////////////////////////////////////////////////////////////

    dsv_core_if cif ();

    logic [dsv_pkg::NUM_PIN-1:0] pins;

    assign pins = {nmi_n, ext_irq_one_to_five, ext_irq_zero};

    dsv_pin_detect #(
        .N       (dsv_pkg::NUM_PIN)
    ) u_detect (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pins),
        .det     (cif.det)
    );

    dsv_chan_route u_route (
        .rt (cif.route)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    logic                       aw_got_reg;
    logic                       aw_got_next;
    logic [dsv_pkg::ADDR_W-1:0] aw_addr_reg;
    logic                       w_got_reg;
    logic                       w_got_next;
    logic [31:0]                w_data_reg;
    logic [3:0]                 w_strb_reg;
    logic                       bvalid_next;
    logic                       do_write;
    logic                       aw_hs;
    logic                       w_hs;

    assign aw_hs    = s_axi_awvalid & s_axi_awready;
    assign w_hs     = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;

    always_comb begin
        aw_got_next = (aw_got_reg | aw_hs) & ~do_write;
        w_got_next  = (w_got_reg | w_hs) & ~do_write;
        bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
        end else begin
            aw_got_reg    <= aw_got_next;
            w_got_reg     <= w_got_next;
            if (aw_hs) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            // hold off new requests until the response is gone
            s_axi_awready <= ~aw_got_next & ~bvalid_next;
            s_axi_wready  <= ~w_got_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write decode; every writable register is one byte in lane zero

    logic [dsv_pkg::NUM_CHAN-1:0] vec_wr;
    logic                         mode_wr;
    logic                         req_wr;
    logic                         start_wr;
    logic                         wr_mapped;
    logic                         lane0;

    assign lane0 = w_strb_reg[0];

    always_comb begin
        for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
            vec_wr[c] = dsv_pkg::reg_hit(aw_addr_reg,
                                         dsv_pkg::IDX_CHAN0_VEC + 8'(c));
        end
        mode_wr   = dsv_pkg::reg_hit(aw_addr_reg, dsv_pkg::IDX_MODE);
        req_wr    = dsv_pkg::reg_hit(aw_addr_reg, dsv_pkg::IDX_REQ);
        start_wr  = dsv_pkg::reg_hit(aw_addr_reg, dsv_pkg::IDX_START);
        wr_mapped = (|vec_wr) | mode_wr | req_wr | start_wr |
                    dsv_pkg::reg_hit(aw_addr_reg, dsv_pkg::IDX_STATUS);
        vec_wr    = vec_wr & {dsv_pkg::NUM_CHAN{do_write & lane0}};
        mode_wr   = mode_wr & do_write & lane0;
        req_wr    = req_wr & do_write & lane0;
        start_wr  = start_wr & do_write & lane0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= dsv_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bresp <= wr_mapped ? dsv_pkg::RESP_OKAY
                                     : dsv_pkg::RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel trigger vectors

    logic [dsv_pkg::NUM_CHAN-1:0][7:0] chan_vec_reg;

    assign cif.vec = chan_vec_reg; // R01

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_vec_reg <= {dsv_pkg::NUM_CHAN{dsv_pkg::VEC_RESET}}; // R07
        end else begin
            for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
                // a rewrite in the same cycle as the end keeps the channel
                if (vec_wr[c]) begin
                    chan_vec_reg[c] <= {
                        w_data_reg[dsv_pkg::VEC_MSB:dsv_pkg::VEC_LSB],
                        2'h0}; // R07 R22
                end else if (transfer_count_zero[c]) begin
                    chan_vec_reg[c] <= dsv_pkg::VEC_RESET; // R03 R06
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transfer_end_irq <= '0;
        end else begin
            transfer_end_irq <= transfer_count_zero; // R03
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input mode control

    logic [7:0] mode_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= dsv_pkg::MODE_RESET;
        end else if (mode_wr) begin
            mode_reg <= {5'h00, w_data_reg[2:0]}; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request latches: ext0..5 and software start

    logic [dsv_pkg::NUM_SRC-1:0] flag_reg;
    logic [dsv_pkg::NUM_SRC-1:0] set_src;
    logic [dsv_pkg::NUM_SRC-1:0] clr_src;
    logic [dsv_pkg::NUM_SRC-1:0] lvl_mode;
    logic [dsv_pkg::NUM_SRC-1:0] owned;
    logic                        nmi_flag_reg;
    logic                        nmi_set;

    always_comb begin
        lvl_mode = '0;
        lvl_mode[dsv_pkg::SRC_EXT0] = mode_reg[dsv_pkg::MODE_EXT0_LVL];
        lvl_mode[dsv_pkg::SRC_EXT5] = mode_reg[dsv_pkg::MODE_EXT5_LVL];
        set_src = {start_wr & w_data_reg[dsv_pkg::START_BIT],
                   cif.rise[dsv_pkg::NUM_EXT-1:0]}; // R08 R10 R12
        owned   = '0;
        clr_src = '0;
        for (int s = 0; s < dsv_pkg::NUM_SRC; s++) begin
            for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
                if (cif.ch_hit[c] && cif.ch_src[c] == 3'(s)) begin
                    owned[s] = 1'b1;
                    if (dma_accept && dma_accept_chan == 2'(c)) begin
                        clr_src[s] = 1'b1; // R21
                    end
                end
            end
            if (vec_read && vec_read_src == 3'(s)) begin
                clr_src[s] = 1'b1; // R21
            end
            if (req_wr && !w_data_reg[s]) begin
                clr_src[s] = 1'b1;
            end
        end
        // entering level mode drops a pending edge request
        if (mode_wr && w_data_reg[dsv_pkg::MODE_EXT0_LVL] &&
            !mode_reg[dsv_pkg::MODE_EXT0_LVL]) begin
            clr_src[dsv_pkg::SRC_EXT0] = 1'b1; // R14 R18
        end
        if (mode_wr && w_data_reg[dsv_pkg::MODE_EXT5_LVL] &&
            !mode_reg[dsv_pkg::MODE_EXT5_LVL]) begin
            clr_src[dsv_pkg::SRC_EXT5] = 1'b1; // R14 R18
        end
        // pin is active low, so its falling edge is the request
        nmi_set = cif.fall[dsv_pkg::PIN_NMI] |
                  (mode_reg[dsv_pkg::MODE_NMI_BOTH] &
                   cif.rise[dsv_pkg::PIN_NMI]); // R11
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= '0; // R21
        end else begin
            for (int s = 0; s < dsv_pkg::NUM_SRC; s++) begin
                if (lvl_mode[s]) begin
                    // the latch tracks the pin, so a later switch back
                    // to edge mode finds the flag as it stood
                    flag_reg[s] <= cif.level[s]; // R13 R18 R15
                end else if (set_src[s]) begin
                    flag_reg[s] <= 1'b1;
                end else if (clr_src[s]) begin
                    flag_reg[s] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_flag_reg <= 1'b0;
        end else if (nmi_set) begin
            nmi_flag_reg <= 1'b1; // R11
        end else if (vec_read && vec_read_src == dsv_pkg::SRC_NMI) begin
            nmi_flag_reg <= 1'b0; // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request outputs

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_req <= '0;
        end else begin
            for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
                dma_req[c] <= cif.ch_hit[c] & flag_reg[cif.ch_src[c]] &
                              ~clr_src[cif.ch_src[c]]; // R01 R05
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req <= '0;
            nmi_req <= 1'b0;
        end else begin
            // a routed source never reaches the normal interrupt path
            irq_req <= flag_reg[dsv_pkg::NUM_EXT-1:0] &
                       ~owned[dsv_pkg::NUM_EXT-1:0]; // R01
            nmi_req <= nmi_flag_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel; trigger vectors read as zero

    logic        ar_hs;
    logic        rvalid_next;
    logic [31:0] rd_word;
    logic        rd_mapped;

    assign ar_hs = s_axi_arvalid & s_axi_arready;

    always_comb begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b1;
        if (dsv_pkg::reg_hit(s_axi_araddr, dsv_pkg::IDX_MODE)) begin
            rd_word = {24'h00_0000, mode_reg};
        end else if (dsv_pkg::reg_hit(s_axi_araddr,
                                      dsv_pkg::IDX_REQ)) begin
            rd_word = {25'h000_0000, flag_reg};
        end else if (dsv_pkg::reg_hit(s_axi_araddr,
                                      dsv_pkg::IDX_STATUS)) begin
            for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
                rd_word[c]     = (chan_vec_reg[c] != dsv_pkg::VEC_RESET);
                rd_word[c + 4] = cif.ch_hit[c];
                rd_word[c + 8] = dma_req[c];
            end
        end else begin
            rd_mapped = dsv_pkg::reg_hit(s_axi_araddr, dsv_pkg::IDX_START);
            for (int c = 0; c < dsv_pkg::NUM_CHAN; c++) begin
                rd_mapped |= dsv_pkg::reg_hit(s_axi_araddr,
                    dsv_pkg::IDX_CHAN0_VEC + 8'(c));
            end
        end
        rvalid_next = ar_hs | (s_axi_rvalid & ~s_axi_rready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dsv_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_mapped ? dsv_pkg::RESP_OKAY
                                         : dsv_pkg::RESP_SLVERR;
            end
        end
    end

endmodule : dsv_irq_ctrl

`default_nettype wire

// ### test/dsv_irq_ctrl_props.sv
// port assertions of the trigger-vector block
`timescale 1ns/1ps
`default_nettype none
module dsv_irq_ctrl_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        nmi_n,
    input wire logic [4:0]  ext_irq_one_to_five,
    input wire logic        dma_accept,
    input wire logic [1:0]  dma_accept_chan,
    input wire logic [3:0]  transfer_count_zero,
    input wire logic        vec_read,
    input wire logic [2:0]  vec_read_src,
    input wire logic [3:0]  dma_req,
    input wire logic [3:0]  transfer_end_irq,
    input wire logic [5:0]  irq_req,
    input wire logic        nmi_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_chan;
        s_axi_arvalid && s_axi_arready &&
        s_axi_araddr >= 12'h098 && s_axi_araddr <= 12'h0A4;
    endsequence
    sequence s_pick_ext1;
        vec_read && vec_read_src == 3'h1;
    endsequence
    a_end_irq_pulse: assert property (
        transfer_end_irq == $past(transfer_count_zero))
        else $error("end pulse late");
    a_accept_drops: assert property (
        dma_accept && dma_accept_chan == 2'h0 |-> ##2 !dma_req[0])
        else $error("accept kept");
    a_vec_read_clr: assert property (
        s_pick_ext1 |-> ##2 !irq_req[1])
        else $error("read kept");
    a_nmi_fall_req: assert property (
        $fell(nmi_n) |-> ##[2:8] nmi_req)
        else $error("nmi lost");
    a_ext1_rise_req: assert property (
        $rose(ext_irq_one_to_five[0]) |->
        ##[2:8] (irq_req[1] || dma_req != 4'h0))
        else $error("ext1 lost");
    a_edge_only_in: assert property (
        $rose(irq_req[1]) |-> !$past(ext_irq_one_to_five[0], 8))
        else $error("ext1 no edge");
    a_rd_vec_zero: assert property (
        s_rd_chan |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("vector readable");
    a_reset_quiet: assert property (
        $rose(aresetn) |-> dma_req == 4'h0 && !nmi_req && !s_axi_bvalid)
        else $error("reset busy");
endmodule : dsv_irq_ctrl_props
bind dsv_irq_ctrl dsv_irq_ctrl_props i_props (.*);
`default_nettype wire

// ### test/dsv_cpu_model.sv
// cpu core model taking transfer and interrupt requests
`timescale 1ns/1ps
`default_nettype none
module dsv_cpu_model (
    input  wire logic       aclk,
    input  wire logic       acc_en,
    input  wire logic       ack_en,
    input  wire logic [3:0] dly,
    input  wire logic [3:0] dma_req,
    input  wire logic [5:0] irq_req,
    input  wire logic       nmi_req,
    output logic            dma_accept,
    output logic [1:0]      dma_accept_chan,
    output logic            vec_read,
    output logic [2:0]      vec_read_src
);
    int i;
    initial begin
        dma_accept = 1'b0;
        vec_read = 1'b0;
        dma_accept_chan = 2'h3;
        vec_read_src = 3'h0;
        forever begin
            @(posedge aclk);
            if (acc_en && dma_req != 4'h0) begin
                repeat (dly) @(posedge aclk);
                for (i = 3; i >= 0; i--)
                    if (dma_req[i]) dma_accept_chan <= 2'(i);
                dma_accept <= 1'b1;
                @(posedge aclk);
                dma_accept <= 1'b0;
                // released qualifier must not look valid
                dma_accept_chan <= ~dma_accept_chan;
                repeat (2) @(posedge aclk);
            end else if (ack_en && (nmi_req || irq_req != 6'h00)) begin
                for (i = 5; i >= 0; i--)
                    if (irq_req[i]) vec_read_src <= 3'(i);
                if (nmi_req) vec_read_src <= 3'h7;
                vec_read <= 1'b1;
                @(posedge aclk);
                vec_read <= 1'b0;
                vec_read_src <= ~vec_read_src;
                repeat (2) @(posedge aclk);
            end
        end
    end
endmodule : dsv_cpu_model
`default_nettype wire

// ### test/dsv_irq_ctrl_tb.sv
// self-checking bench for the trigger-vector block
`timescale 1ns/1ps
`default_nettype none
module dsv_irq_ctrl_tb;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF, transfer_count_zero = '0, dly = '0;
    logic [3:0]  dma_req, transfer_end_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, dma_accept_chan, r;
    logic [2:0]  vec_read_src;
    logic [5:0]  ext = '0, irq_req;
    logic [4:0]  ext_irq_one_to_five;
    logic aclk = 0, aresetn = 0, nmi_n = 1, acc_en = 0, ack_en = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_irq_zero, dma_accept, vec_read, nmi_req;
    int   fail_count = 0, compares = 0, cyc = 0;
    assign ext_irq_zero = ext[0];
    assign ext_irq_one_to_five = ext[5:1];
    dsv_irq_ctrl i_dut (.*);
    dsv_cpu_model i_cpu (.*);
    task automatic wrap_up;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge aclk);
    endtask : w
    task automatic wr(input logic [7:0] i, input logic [31:0] v);
        bit a = 1, b = 1;
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (a || b) begin
            @(posedge aclk);
            if (a && s_axi_awready) begin a = 0; s_axi_awvalid <= 0; end
            if (b && s_axi_wready) begin b = 0; s_axi_wvalid <= 0; end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk("bresp", s_axi_bresp, dsv_pkg::RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
    task automatic pulse(input int s);
        ext[s] <= 1; w(6); ext[s] <= 0; w(8);
    endtask : pulse
    task automatic acc;
        acc_en <= 1; w(8); acc_en <= 0; w(2);
    endtask : acc
    task automatic ack;
        ack_en <= 1; w(8); ack_en <= 0; w(2);
    endtask : ack
    task automatic done(input int c);
        transfer_count_zero[c] <= 1; w(1); transfer_count_zero <= '0; w(2);
    endtask : done
    task automatic t_route;
        rd(12'h098); chk("vec rd", d, 0);
        rd(12'hFF0); chk("unmap", r, dsv_pkg::RESP_SLVERR);
        wr(8'h26, 32'h0000_002B); wr(8'h27, 32'h0000_0028);
        pulse(0); chk("chain0", dma_req, 4'h1);
        acc; chk("acc", dma_req, 4'h0);
        done(0); rd(12'h0B4); chk("own", d[3:0], 4'h2);
        pulse(0); chk("chain1", dma_req, 4'h2);
        chk("no irq", irq_req, 6'h00);
        acc; done(1);
    endtask : t_route
    task automatic t_codes;
        dly <= 4'h4;
        for (int s = 0; s < 6; s++) begin
            wr(8'h29, 32'h0000_0028 + 32'(4 * s));
            pulse(s); chk("code", dma_req, 4'h8);
            acc; done(3);
        end
        wr(8'h28, 32'h0000_00FC); wr(8'h2C, 32'h0000_0001); w(8);
        chk("sw", dma_req, 4'h4);
        acc; done(2); dly <= 4'h0;
    endtask : t_codes
    task automatic t_pins;
        ext[1] <= 1; w(8); chk("e1", irq_req[1], 1);
        wr(8'h2B, 32'h0000_007D); w(8);
        chk("e1 hold", irq_req[1], 0);
        ext[1] <= 0; w(8); pulse(1); ack;
        chk("vrd", irq_req[1], 0);
        pulse(0); chk("e0", irq_req[0], 1);
        wr(8'h2A, 32'h0000_0002); w(4); chk("lvl", irq_req[0], 0);
        ext[0] <= 1; w(8); chk("lvl hi", irq_req[0], 1);
        ext[0] <= 0; w(8); chk("lvl lo", irq_req[0], 0);
        ext[0] <= 1; w(8); wr(8'h2A, 0); ext[0] <= 0; w(8);
        chk("edge", irq_req[0], 1);
        wr(8'h2B, 32'h0000_007E); w(4); chk("clr", irq_req[0], 0);
        nmi_n <= 0; w(8); chk("nmi", nmi_req, 1);
        ack; nmi_n <= 1; w(8); chk("nmi off", nmi_req, 0);
        wr(8'h2A, 32'h0000_0001); nmi_n <= 0; w(8); ack; nmi_n <= 1; w(8);
        chk("nmi on", nmi_req, 1);
    endtask : t_pins
    initial forever #4 aclk = ~aclk;
    // a hang counts as a mismatch
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin fail_count++; wrap_up; end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        w(2);
        t_route;
        t_codes;
        t_pins;
        wrap_up;
    end
endmodule : dsv_irq_ctrl_tb
`default_nettype wire
